//--- pmbs_dev.sv
// Purpose: Module end: reset, boot straps, power modes, interface detection
// Assumes: Host keeps to its side of the link; activity and radio mode come from the core
// Notes:   Command settings model stored configuration and survive reboots; srst clears them
// What this block does
// - Low reset pin reboots module; pulled up idle
// - Reboot command gives software reset like reboot
// - Boot-ready message when command mode configured
// - Active/standby switch alone; wake immediately, lossless
// - Active mode runs processor at fastest clock
// - Auto scaling lowers clocks, caps baud 1M
// - Sleep keeps links, withholds UART output
// - After enable, data-set-ready toggles sleep
// - Sleep only with radio station or off
// - Stop halts all; leaving stop reboots
// - After enable, data-set-ready toggles stop
// - Command assigns GPIO to enter/leave stop
// - Command-set timer ends stop after delay
// - Boot strap: low factory, high flash; refclk
// - Log strap: high diagnostics on transmit; chip select
// - Flash strap must be high; then data out
// - Host leaves strap pins undriven during boot
// - After boot, watch pins to pick interface
`timescale 1ns/1ns
`default_nettype none
module pmbs_dev
	import pmbs_pkg::*;
#(
	parameter int BOOT_LEN  = BOOT_CYCLES,
	parameter int IDLE_LEN  = IDLE_CYCLES,
	parameter int MS_LEN    = MS_CYCLES
)(
	input  wire logic         clk,
	input  wire logic         srst,
	pmbs_link_if.dev          lnk,
	input  wire logic         cmd_mode_cfg,
	input  wire logic [1:0]   radio_mode,
	input  wire logic         activity,
	input  wire logic         rx_valid,
	input  wire logic [7:0]   rx_data,
	input  wire logic [15:0]  baud_div_req,
	input  wire logic         spi_out_bit,
	output pmbs_state_t       power_state,
	output logic              core_reset,
	output logic [1:0]        cpu_clk_div,
	output logic [15:0]       baud_div,
	output logic              auto_scale,
	output logic              boot_factory,
	output logic              boot_log_en,
	output logic              flash_1v8,
	output logic              strap_fault,
	output pmbs_iface_t       iface_sel
);
	pmbs_state_t state;
	pmbs_state_t next_state;
	logic [7:0]  s1;
	logic [7:0]  s2;
	logic [7:0]  s3;
	logic [7:0]  lvl;
	logic [7:0]  lvl_prev;
	logic [15:0] boot_cnt;
	logic [15:0] idle_cnt;
	logic        sleep_en;
	logic        stop_en;
	logic        gpio_src_en;
	logic [15:0] timer_ms;
	logic [15:0] stop_ms;
	logic [31:0] ms_pre;
	logic        straps_done;
	logic [3:0]  eth_cnt;
	logic [3:0]  spi_cnt;
	logic [7:0]  drdy_cnt;
	logic        drdy_q;
	logic        tx_valid_q;
	logic [7:0]  tx_data_q;
	logic        startup_q;

	// Pin levels count once two later stages agree; the first stage feeds only the second
	wire [7:0] raw = {lnk.miso_pin, lnk.sclk, lnk.rxd, lnk.cs_pin, lnk.boot_pin,
		lnk.gpio_stop, lnk.dsr, lnk.rst_n_pin};
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s1 <= SYNC_INIT;
			s2 <= SYNC_INIT;
			s3 <= SYNC_INIT;
			lvl <= SYNC_INIT;
			lvl_prev <= SYNC_INIT;
		end
		else
		begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
			lvl <= (s2 & s3) | (lvl & (s2 | s3));
			lvl_prev <= lvl;
		end
	end

	// Decoded events
	wire [7:0] rise     = lvl & ~lvl_prev;
	wire [7:0] fall     = ~lvl & lvl_prev;
	wire [7:0] chg      = lvl ^ lvl_prev;
	wire hw_reset       = ~lvl[SY_RST];
	wire running        = (state == PS_ACTIVE) || (state == PS_STANDBY);
	wire cmd_fire       = lnk.cmd_valid && running;
	wire sw_reboot      = cmd_fire && (lnk.cmd_op == CMD_SW_REBOOT);
	wire radio_ok       = (radio_mode == RADIO_STATION) || (radio_mode == RADIO_OFF);
	wire dsr_stop       = stop_en && chg[SY_DSR];
	wire gpio_stop_evt  = gpio_src_en && chg[SY_GPIO];
	wire stop_req       = dsr_stop || gpio_stop_evt;
	wire sleep_req      = sleep_en && !stop_en && chg[SY_DSR] && radio_ok;
	wire timer_wake     = (timer_ms != 16'h0000) && (stop_ms == 16'h0000);
	wire boot_last      = boot_cnt == 16'(BOOT_LEN - 1);
	wire idle_done      = idle_cnt == 16'(IDLE_LEN - 1);
	wire ms_tick        = ms_pre == 32'(MS_LEN - 1);
	wire strap_latch    = (state == PS_BOOT) && (boot_cnt == STRAP_LATCH_CYC);
	wire detecting      = running && (iface_sel == IF_NONE);
	wire boot_done_evt  = (state == PS_BOOT) && boot_last && !hw_reset;

	// Power state transitions; reset pin and reboot command win over everything
	always_comb
	begin
		next_state = state;
		case (state)
			PS_RESET:   if (!hw_reset) next_state = PS_BOOT;
			PS_BOOT:    if (boot_last) next_state = PS_ACTIVE;
			PS_ACTIVE:
				if (stop_req) next_state = PS_STOP;
				else if (sleep_req) next_state = PS_SLEEP;
				else if (idle_done) next_state = PS_STANDBY;
			PS_STANDBY:
				if (stop_req) next_state = PS_STOP;
				else if (sleep_req) next_state = PS_SLEEP;
				else if (activity || lnk.cmd_valid || rx_valid) next_state = PS_ACTIVE;
			PS_SLEEP:
				if (gpio_stop_evt) next_state = PS_STOP;
				else if (sleep_en && chg[SY_DSR]) next_state = PS_ACTIVE;
			PS_STOP:    if (stop_req || timer_wake) next_state = PS_RESET;
			default:    next_state = PS_RESET;
		endcase
		if (hw_reset || sw_reboot)
			next_state = PS_RESET;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			state <= PS_RESET;
		else
			state <= next_state;
	end

	// Boot and idle counters; idle restarts on any activity so no packet waits on a wake
	always_ff @(posedge clk)
	begin
		if (srst || state != PS_BOOT)
			boot_cnt <= 16'h0000;
		else
			boot_cnt <= boot_cnt + 16'h0001;
		if (srst || state != PS_ACTIVE || activity || rx_valid || lnk.cmd_valid)
			idle_cnt <= 16'h0000;
		else
			idle_cnt <= idle_cnt + 16'h0001;
	end

	// Command settings; held across reboots like stored configuration
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			sleep_en <= 1'b0;
			stop_en <= 1'b0;
			gpio_src_en <= 1'b0;
			timer_ms <= 16'h0000;
			auto_scale <= 1'b0;
		end
		else if (cmd_fire)
		begin
			case (lnk.cmd_op)
				CMD_POWER_MANAGE:     auto_scale <= lnk.cmd_arg[0];
				CMD_SLEEP_TOGGLE_EN:  sleep_en <= lnk.cmd_arg[0];
				CMD_STOP_TOGGLE_EN:   stop_en <= lnk.cmd_arg[0];
				CMD_STOP_SOURCE_GPIO: gpio_src_en <= lnk.cmd_arg[0];
				CMD_STOP_SOURCE_TMR:  timer_ms <= lnk.cmd_arg;
				default:              sleep_en <= sleep_en;
			endcase
		end
	end

	// Wake timer runs only in stop; reloaded on every entry
	always_ff @(posedge clk)
	begin
		if (srst || state != PS_STOP)
		begin
			ms_pre <= 32'h0000_0000;
			stop_ms <= timer_ms;
		end
		else if (ms_tick)
		begin
			ms_pre <= 32'h0000_0000;
			if (stop_ms != 16'h0000)
				stop_ms <= stop_ms - 16'h0001;
		end
		else
			ms_pre <= ms_pre + 32'h0000_0001;
	end

	// Straps are sampled a few cycles after release, once the synchroniser has settled
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			straps_done <= 1'b0;
			boot_factory <= 1'b0;
			boot_log_en <= 1'b1;
			flash_1v8 <= 1'b1;
			strap_fault <= 1'b0;
		end
		else if (state == PS_RESET)
			straps_done <= 1'b0;
		else if (strap_latch && !straps_done)
		begin
			straps_done <= 1'b1;
			boot_factory <= ~lvl[SY_BOOT];
			boot_log_en <= lvl[SY_CS];
			flash_1v8 <= lvl[SY_MISO];
			strap_fault <= ~lvl[SY_MISO];
		end
	end

	// Data-out role of the flash strap only after sampling; never driven in reset, boot or stop
	assign lnk.miso_d_o    = spi_out_bit;
	assign lnk.miso_d_oe_n = ~(straps_done && (running || state == PS_SLEEP));

	// Interface detection after boot: refclk edges, eight serial clocks, or a start bit
	always_ff @(posedge clk)
	begin
		if (srst || !straps_done)
		begin
			iface_sel <= IF_NONE;
			eth_cnt <= 4'h0;
			spi_cnt <= 4'h0;
		end
		else if (detecting)
		begin
			if (rise[SY_BOOT])
				eth_cnt <= eth_cnt + 4'h1;
			if (rise[SY_SCLK])
				spi_cnt <= spi_cnt + 4'h1;
			if (eth_cnt == ETH_EDGES)
				iface_sel <= IF_ETH;
			else if (spi_cnt == SPI_EDGES)
				iface_sel <= IF_SPI;
			else if (fall[SY_RXD])
				iface_sel <= IF_UART;
		end
	end

	// Data-ready toggles only while looking for a master; stops when UART wins
	always_ff @(posedge clk)
	begin
		if (srst || !detecting)
		begin
			drdy_cnt <= 8'h00;
			drdy_q <= 1'b0;
		end
		else if (drdy_cnt == DRDY_HALF_CYC)
		begin
			drdy_cnt <= 8'h00;
			drdy_q <= ~drdy_q;
		end
		else
			drdy_cnt <= drdy_cnt + 8'h01;
	end

	// Transmit path: diagnostics first, then ready marker, then forwarded data
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			tx_valid_q <= 1'b0;
			tx_data_q <= 8'h00;
			startup_q <= 1'b0;
		end
		else
		begin
			startup_q <= boot_done_evt && cmd_mode_cfg;
			tx_valid_q <= (boot_done_evt && cmd_mode_cfg) || (strap_latch && lvl[SY_CS] && !straps_done)
				|| (rx_valid && running);
			if (boot_done_evt && cmd_mode_cfg)
				tx_data_q <= READY_BYTE;
			else if (strap_latch && !straps_done)
				tx_data_q <= DIAG_BYTE;
			else
				tx_data_q <= rx_data;
		end
	end

	assign lnk.tx_valid  = tx_valid_q;
	assign lnk.tx_data   = tx_data_q;
	assign lnk.startup   = startup_q;
	assign lnk.drdy      = drdy_q;
	assign lnk.cmd_ready = running;

	// Clock and baud selection, registered
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cpu_clk_div <= CLK_DIV_MAX;
			baud_div <= BAUD_CAP_DIV;
			core_reset <= 1'b1;
		end
		else
		begin
			cpu_clk_div <= (state == PS_ACTIVE || !auto_scale) ? CLK_DIV_MAX : CLK_DIV_LOW;
			baud_div <= (auto_scale && baud_div_req < BAUD_CAP_DIV) ? BAUD_CAP_DIV : baud_div_req;
			core_reset <= (next_state == PS_RESET) || (next_state == PS_STOP);
		end
	end

	assign power_state = state;
endmodule
`default_nettype wire

//--- pmbs_pkg.sv
// Purpose: Shared constants and types for the power mode and boot strap control pair
// Assumes: 100 MHz clock on both ends
// Notes:   Counts above 4096 cycles are only defaults here; the modules take them as parameters
`default_nettype none
package pmbs_pkg;
	typedef enum logic [5:0] {
		PS_RESET   = 6'h01,
		PS_BOOT    = 6'h02,
		PS_ACTIVE  = 6'h04,
		PS_STANDBY = 6'h08,
		PS_SLEEP   = 6'h10,
		PS_STOP    = 6'h20
	} pmbs_state_t;
	typedef enum logic [3:0] {
		IF_NONE = 4'h1,
		IF_UART = 4'h2,
		IF_ETH  = 4'h4,
		IF_SPI  = 4'h8
	} pmbs_iface_t;
	// Host command codes carried on the command channel
	localparam logic [2:0] CMD_SW_REBOOT        = 3'h1;
	localparam logic [2:0] CMD_POWER_MANAGE     = 3'h2;
	localparam logic [2:0] CMD_SLEEP_TOGGLE_EN  = 3'h3;
	localparam logic [2:0] CMD_STOP_TOGGLE_EN   = 3'h4;
	localparam logic [2:0] CMD_STOP_SOURCE_GPIO = 3'h5;
	localparam logic [2:0] CMD_STOP_SOURCE_TMR  = 3'h6;
	// Radio operating modes reported by the core
	localparam logic [1:0] RADIO_OFF     = 2'h0;
	localparam logic [1:0] RADIO_STATION = 2'h1;
	// Timing
	localparam int          CLK_NS          = 10;
	localparam int          CLK_HZ          = 100_000_000;
	localparam int          MS_NS           = 1_000_000;
	localparam int          MS_CYCLES       = MS_NS / CLK_NS;
	localparam int          BAUD_CAP        = 1_000_000;
	localparam logic [15:0] BAUD_CAP_DIV    = 16'(CLK_HZ / BAUD_CAP);
	localparam int          BOOT_CYCLES     = 256;
	localparam logic [15:0] STRAP_LATCH_CYC = 16'h0004;
	localparam int          IDLE_CYCLES     = 64;
	localparam logic [7:0]  DRDY_HALF_CYC   = 8'h1f;
	localparam logic [3:0]  ETH_EDGES       = 4'h4;
	localparam logic [3:0]  SPI_EDGES       = 4'h8;
	localparam int          RESET_HOLD_CYC  = 16;
	// Clock divider codes: 0 is the fastest processor clock
	localparam logic [1:0]  CLK_DIV_MAX     = 2'h0;
	localparam logic [1:0]  CLK_DIV_LOW     = 2'h2;
	// Byte sent on the transmit line as boot diagnostics and as boot-ready marker
	localparam logic [7:0]  DIAG_BYTE       = 8'h44;
	localparam logic [7:0]  READY_BYTE      = 8'h53;
	// Pin synchroniser bit positions and idle levels
	localparam int          SY_RST  = 0;
	localparam int          SY_DSR  = 1;
	localparam int          SY_GPIO = 2;
	localparam int          SY_BOOT = 3;
	localparam int          SY_CS   = 4;
	localparam int          SY_RXD  = 5;
	localparam int          SY_SCLK = 6;
	localparam int          SY_MISO = 7;
	localparam logic [7:0]  SYNC_INIT = 8'hbf;
endpackage
`default_nettype wire

//--- pmbs_link_if.sv
// Purpose: Pins between host processor and module, with pull-ups resolved here
// Assumes: Both ends share one clock; pins are still synchronised at the module
// Notes:   Output enables are active low
`timescale 1ns/1ns
`default_nettype none
interface pmbs_link_if;
	logic       rst_n_o;
	logic       rst_n_oe_n;
	logic       rst_n_pin;
	logic       dsr;
	logic       gpio_stop;
	logic       rxd;
	logic       sclk;
	logic       cmd_valid;
	logic [2:0] cmd_op;
	logic [15:0] cmd_arg;
	logic       cmd_ready;
	logic       tx_valid;
	logic [7:0] tx_data;
	logic       startup;
	logic       drdy;
	logic       boot_h_o;
	logic       boot_h_oe_n;
	logic       boot_pin;
	logic       cs_h_o;
	logic       cs_h_oe_n;
	logic       cs_pin;
	logic       miso_d_o;
	logic       miso_d_oe_n;
	logic       miso_pin;

	// Internal pull-ups make every undriven pin read high
	assign rst_n_pin = rst_n_oe_n ? 1'b1 : rst_n_o;
	assign boot_pin  = boot_h_oe_n ? 1'b1 : boot_h_o;
	assign cs_pin    = cs_h_oe_n ? 1'b1 : cs_h_o;
	assign miso_pin  = miso_d_oe_n ? 1'b1 : miso_d_o;

	modport dev (input rst_n_pin, dsr, gpio_stop, rxd, sclk, cmd_valid, cmd_op, cmd_arg,
		boot_pin, cs_pin, miso_pin,
		output cmd_ready, tx_valid, tx_data, startup, drdy, miso_d_o, miso_d_oe_n);
	modport host (output rst_n_o, rst_n_oe_n, dsr, gpio_stop, rxd, sclk, cmd_valid, cmd_op, cmd_arg,
		boot_h_o, boot_h_oe_n, cs_h_o, cs_h_oe_n,
		input cmd_ready, tx_valid, tx_data, startup, drdy, miso_pin, rst_n_pin);
endinterface
`default_nettype wire

//--- pmbs_host.sv
// Purpose: Host end: drives reset, data-set-ready, stop GPIO and commands
// Assumes: Reset pin is open drain, pulled up at the module
// Notes:   Shared pins stay released until boot-ready, and whenever the module takes no commands
`timescale 1ns/1ns
`default_nettype none
module pmbs_host
	import pmbs_pkg::*;
#(
	parameter int HOLD_LEN = RESET_HOLD_CYC
)(
	input  wire logic        clk,
	input  wire logic        srst,
	pmbs_link_if.host        lnk,
	input  wire logic        reset_req,
	input  wire logic        dsr_toggle,
	input  wire logic        gpio_toggle,
	input  wire logic        cmd_valid,
	input  wire logic [2:0]  cmd_op,
	input  wire logic [15:0] cmd_arg,
	output logic             cmd_ready,
	input  wire logic        rxd_in,
	input  wire logic        sclk_in,
	input  wire logic        cs_in,
	input  wire logic        eth_clk_en,
	output logic             boot_seen,
	output logic             rx_valid,
	output logic [7:0]       rx_data,
	output logic             miso_bit,
	output logic             reset_busy
);
	logic [15:0] hold_cnt;
	logic        dsr_q;
	logic        gpio_q;
	logic        refclk_q;
	logic [1:0]  ref_div;

	// Reset pulse is stretched and only ever pulls low
	always_ff @(posedge clk)
	begin
		if (srst)
			hold_cnt <= 16'h0000;
		else if (reset_req)
			hold_cnt <= 16'(HOLD_LEN);
		else if (hold_cnt != 16'h0000)
			hold_cnt <= hold_cnt - 16'h0001;
	end
	assign reset_busy     = hold_cnt != 16'h0000;
	assign lnk.rst_n_o    = 1'b0;
	assign lnk.rst_n_oe_n = ~reset_busy;

	// Each request flips the control lines once
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			dsr_q <= 1'b1;
			gpio_q <= 1'b1;
			refclk_q <= 1'b0;
			ref_div <= 2'h0;
			boot_seen <= 1'b0;
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
			miso_bit <= 1'b1;
		end
		else
		begin
			if (dsr_toggle)
				dsr_q <= ~dsr_q;
			if (gpio_toggle)
				gpio_q <= ~gpio_q;
			// Two cycles high, two low: a one-cycle toggle would never pass the module's pin filter
			ref_div <= ref_div + 2'h1;
			refclk_q <= eth_clk_en && boot_seen && ref_div[1];
			if (reset_req || !lnk.rst_n_pin)
				boot_seen <= 1'b0;
			else if (lnk.startup)
				boot_seen <= 1'b1;
			rx_valid <= lnk.tx_valid;
			rx_data <= lnk.tx_data;
			miso_bit <= lnk.miso_pin;
		end
	end

	assign lnk.dsr         = dsr_q;
	assign lnk.gpio_stop   = gpio_q;
	assign lnk.rxd         = rxd_in;
	assign lnk.sclk        = sclk_in;
	assign lnk.cmd_valid   = cmd_valid;
	assign lnk.cmd_op      = cmd_op;
	assign lnk.cmd_arg     = cmd_arg;
	assign cmd_ready       = lnk.cmd_ready;
	// Strap pins stay undriven until boot-ready; a reboot or stop drops ready at once, so they let go
	assign lnk.boot_h_o    = refclk_q;
	assign lnk.boot_h_oe_n = ~(boot_seen && eth_clk_en && lnk.cmd_ready);
	assign lnk.cs_h_o      = cs_in;
	assign lnk.cs_h_oe_n   = ~(boot_seen && lnk.cmd_ready);
endmodule
`default_nettype wire

//--- pmbs_link_asserts.sv
// Purpose: Checks on the link between the host end and the module end
// Assumes: HOLD_LEN 8, BOOT_LEN 16, command mode on
// Notes:   Toggle enables are shadowed here from the commands seen on the link
`timescale 1ns/1ns
`default_nettype none
module pmbs_link_asserts
	import pmbs_pkg::*;
(
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        rst_n_oe_n,
	input wire logic        rst_n_pin,
	input wire logic        dsr,
	input wire logic        cmd_valid,
	input wire logic [2:0]  cmd_op,
	input wire logic [15:0] cmd_arg,
	input wire logic        cmd_ready,
	input wire logic        tx_valid,
	input wire logic [7:0]  tx_data,
	input wire logic        startup,
	input wire logic        drdy,
	input wire logic        boot_h_oe_n,
	input wire logic        cs_h_oe_n,
	input wire logic        miso_d_oe_n,
	input wire logic [1:0]  radio_mode
);
	logic sleep_en;
	logic stop_en;
	wire  take_cmd;
	wire  asleep;
	wire  stopped;

	// Sleep keeps the data output driven, stop lets it go, which tells the two apart
	assign take_cmd = cmd_valid && cmd_ready;
	assign asleep   = !cmd_ready && !miso_d_oe_n;
	assign stopped  = !cmd_ready && miso_d_oe_n;

	// Settings survive reboots, so only srst clears the shadows
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			sleep_en <= 1'b0;
			stop_en  <= 1'b0;
		end
		else if (take_cmd && cmd_op == CMD_SLEEP_TOGGLE_EN)
			sleep_en <= cmd_arg[0];
		else if (take_cmd && cmd_op == CMD_STOP_TOGGLE_EN)
			stop_en <= cmd_arg[0];
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	// Boot sends the diagnostic byte, then the ready marker
	sequence s_diag;
		tx_valid && tx_data == DIAG_BYTE;
	endsequence
	sequence s_ready;
		startup && tx_valid && tx_data == READY_BYTE;
	endsequence

	property p_pin_reset;
		$fell(rst_n_pin) |-> ##[2:6] !cmd_ready [*3];
	endproperty
	property p_hold;
		$fell(rst_n_oe_n) |-> !rst_n_oe_n [*8] ##1 rst_n_oe_n;
	endproperty
	property p_sw_reboot;
		take_cmd && cmd_op == CMD_SW_REBOOT |-> ##[1:2] !cmd_ready [*3];
	endproperty
	property p_boot;
		$rose(rst_n_pin) |-> ##[4:14] s_diag ##[4:20] s_ready;
	endproperty
	property p_startup;
		startup |-> s_ready ##1 !startup;
	endproperty
	property p_stop_dsr;
		$changed(dsr) && stop_en && cmd_ready |-> ##[3:7] stopped [*2];
	endproperty
	property p_sleep_dsr;
		$changed(dsr) && sleep_en && !stop_en && cmd_ready
			&& (radio_mode == RADIO_STATION || radio_mode == RADIO_OFF) |-> ##[3:7] asleep;
	endproperty
	property p_sleep_quiet;
		asleep [*2] |-> !tx_valid;
	endproperty
	property p_reset_quiet;
		!rst_n_pin [*7] |-> miso_d_oe_n && !drdy && !cmd_ready;
	endproperty
	// Reset, boot and stop all drop ready, and the host must let the straps go for all of them
	property p_strap_free;
		(!rst_n_pin || !cmd_ready) |-> boot_h_oe_n && cs_h_oe_n;
	endproperty

	a_pin_reset: assert property (p_pin_reset) else $error("low reset pin ignored");
	a_hold: assert property (p_hold) else $error("reset pin hold length wrong");
	a_sw_reboot: assert property (p_sw_reboot) else $error("reboot command ignored");
	a_boot: assert property (p_boot) else $error("boot bytes missing or late");
	a_startup: assert property (p_startup) else $error("ready marker malformed");
	a_stop_dsr: assert property (p_stop_dsr) else $error("toggle did not stop");
	a_sleep_dsr: assert property (p_sleep_dsr) else $error("toggle did not sleep");
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("byte sent while asleep");
	a_reset_quiet: assert property (p_reset_quiet) else $error("pins active in reset");
	a_strap_free: assert property (p_strap_free) else $error("host drove strap pin");
endmodule
`default_nettype wire

//--- tb_top.sv
// Purpose: Directed bench for the host end and module end joined by the link
// Assumes: Short counts BOOT_LEN 16, IDLE_LEN 8, MS_LEN 10, HOLD_LEN 8
// Notes:   Each boot forwards two bytes to the host, so byte counts mark the reboots
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import pmbs_pkg::*;
;
	logic        clk, srst, reset_req, dsr_toggle, gpio_toggle, cmd_valid, rxd_in, sclk_in;
	logic        activity, rx_valid, cmd_ready, boot_seen, h_rx_valid, miso_bit, reset_busy;
	logic        core_reset, auto_scale, boot_factory, boot_log_en, flash_1v8, strap_fault;
	logic [2:0]  cmd_op;
	logic [1:0]  cpu_clk_div;
	logic [15:0] cmd_arg, baud_div_req, baud_div;
	logic [7:0]  rx_data, h_rx_data;
	logic        cs_in, eth_clk_en, spi_out_bit;
	logic [1:0]  radio_mode;
	pmbs_state_t power_state;
	pmbs_iface_t iface_sel;
	int          num_errors = 0;
	int          check_count = 0;
	int          rx_count = 0;

	pmbs_link_if u_pmbs_link_if();
	pmbs_host #(.HOLD_LEN(8)) u_pmbs_host (
		.clk(clk), .srst(srst), .lnk(u_pmbs_link_if), .reset_req(reset_req), .dsr_toggle(dsr_toggle),
		.gpio_toggle(gpio_toggle), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready),
		.rxd_in(rxd_in), .sclk_in(sclk_in), .cs_in(cs_in), .eth_clk_en(eth_clk_en), .boot_seen(boot_seen),
		.rx_valid(h_rx_valid), .rx_data(h_rx_data), .miso_bit(miso_bit), .reset_busy(reset_busy));
	pmbs_dev #(.BOOT_LEN(16), .IDLE_LEN(8), .MS_LEN(10)) u_pmbs_dev (
		.clk(clk), .srst(srst), .lnk(u_pmbs_link_if), .cmd_mode_cfg(1'b1), .radio_mode(radio_mode),
		.activity(activity), .rx_valid(rx_valid), .rx_data(rx_data), .baud_div_req(baud_div_req),
		.spi_out_bit(spi_out_bit),
		.power_state(power_state), .core_reset(core_reset), .cpu_clk_div(cpu_clk_div), .baud_div(baud_div),
		.auto_scale(auto_scale), .boot_factory(boot_factory), .boot_log_en(boot_log_en), .flash_1v8(flash_1v8),
		.strap_fault(strap_fault), .iface_sel(iface_sel));
	pmbs_link_asserts u_pmbs_link_asserts (
		.clk(clk), .srst(srst), .rst_n_oe_n(u_pmbs_link_if.rst_n_oe_n), .rst_n_pin(u_pmbs_link_if.rst_n_pin),
		.dsr(u_pmbs_link_if.dsr), .cmd_valid(u_pmbs_link_if.cmd_valid), .cmd_op(u_pmbs_link_if.cmd_op),
		.cmd_arg(u_pmbs_link_if.cmd_arg), .cmd_ready(u_pmbs_link_if.cmd_ready), .tx_valid(u_pmbs_link_if.tx_valid),
		.tx_data(u_pmbs_link_if.tx_data), .startup(u_pmbs_link_if.startup), .drdy(u_pmbs_link_if.drdy),
		.boot_h_oe_n(u_pmbs_link_if.boot_h_oe_n), .cs_h_oe_n(u_pmbs_link_if.cs_h_oe_n),
		.miso_d_oe_n(u_pmbs_link_if.miso_d_oe_n), .radio_mode(radio_mode));

	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Bytes the host received; dropped bytes never show here
	always @(posedge clk)
		if (h_rx_valid === 1'b1)
			rx_count++;

	// Inputs move 1 ns after the edge so no race with the design's sampling
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
		check_count++;
		if (seen !== expv)
		begin
			num_errors++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, expv);
		end
	endtask

	// One-cycle pulse: 0 reset request, 1 data-set-ready toggle, 2 stop pin toggle
	task automatic pulse(input int which);
		{reset_req, dsr_toggle, gpio_toggle} = 3'h4 >> which;
		tick(1);
		{reset_req, dsr_toggle, gpio_toggle} = 3'h0;
	endtask

	// Command held until an edge sees ready, then one more edge for the effect to land
	task automatic send(input logic [2:0] op, input logic [15:0] arg);
		logic ok;
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_arg = arg;
		ok = 1'b0;
		for (int i = 0; i < 20 && !ok; i++)
		begin
			ok = cmd_ready;
			tick(1);
		end
		cmd_valid = 1'b0;
		tick(1);
	endtask

	task automatic wait_for(input pmbs_state_t st);
		for (int i = 0; i < 200 && power_state !== st; i++)
			tick(1);
	endtask

	task automatic close_out;
		if (num_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Cuts a hang short; the scenarios need well under a thousand cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		close_out();
	end

	// Scenarios in order: boot, idle, scaling, detection, reboot, sleep, stop by data-set-ready, pin, timer, hard reset, refclk detection
	initial
	begin
		{srst, reset_req, dsr_toggle, gpio_toggle, cmd_valid, activity, rx_valid, rxd_in, sclk_in} = 9'h102;
		cmd_op = 3'h0;
		cmd_arg = 16'h0000;
		rx_data = 8'h00;
		baud_div_req = 16'h0014;
		{cs_in, eth_clk_en, spi_out_bit, radio_mode} = {3'h4, RADIO_STATION};
		tick(6);
		srst = 1'b0;
		wait_for(PS_ACTIVE);
		tick(1);
		// Transmit data follows the forwarding input after the marker, so look while it stands
		chk(h_rx_data, READY_BYTE);
		tick(2);
		chk({boot_factory, boot_log_en, flash_1v8, strap_fault}, 4'h6);
		chk(rx_count[15:0], 16'h0002);
		chk(miso_bit, 1'b0);
		chk(cpu_clk_div, CLK_DIV_MAX);
		// Host now drives chip select low, so every later boot must find the strap released
		cs_in = 1'b0;
		tick(10);
		chk(power_state, PS_STANDBY);
		rx_data = 8'ha5;
		rx_valid = 1'b1;
		tick(1);
		rx_valid = 1'b0;
		chk(power_state, PS_ACTIVE);
		tick(1);
		chk(h_rx_data, 8'ha5);
		send(CMD_POWER_MANAGE, 16'h0001);
		chk(auto_scale, 1'b1);
		chk(baud_div, BAUD_CAP_DIV);
		tick(12);
		chk(cpu_clk_div, CLK_DIV_LOW);
		activity = 1'b1;
		tick(3);
		chk(cpu_clk_div, CLK_DIV_MAX);
		activity = 1'b0;
		send(CMD_POWER_MANAGE, 16'h0000);
		for (int i = 0; i < 8; i++)
		begin
			sclk_in = 1'b1;
			tick(2);
			sclk_in = 1'b0;
			tick(2);
		end
		tick(4);
		chk(iface_sel, IF_SPI);
		send(CMD_SW_REBOOT, 16'h0000);
		// One edge in reset after the command, so boot has begun when the call returns
		chk(power_state, PS_BOOT);
		wait_for(PS_ACTIVE);
		chk(iface_sel, IF_NONE);
		chk(boot_log_en, 1'b1);
		rxd_in = 1'b0;
		tick(6);
		rxd_in = 1'b1;
		chk(iface_sel, IF_UART);
		send(CMD_SLEEP_TOGGLE_EN, 16'h0001);
		pulse(1);
		tick(6);
		chk(power_state, PS_SLEEP);
		rx_valid = 1'b1;
		spi_out_bit = 1'b1;
		tick(1);
		rx_valid = 1'b0;
		tick(2);
		chk({power_state, rx_count[9:0]}, {PS_SLEEP, 10'h005});
		chk(miso_bit, 1'b1);
		spi_out_bit = 1'b0;
		pulse(1);
		tick(6);
		chk(power_state, PS_ACTIVE);
		radio_mode = 2'h2;
		pulse(1);
		tick(6);
		chk(power_state === PS_SLEEP, 1'b0);
		radio_mode = RADIO_STATION;
		send(CMD_SLEEP_TOGGLE_EN, 16'h0000);
		send(CMD_STOP_TOGGLE_EN, 16'h0001);
		pulse(1);
		tick(8);
		chk({power_state, core_reset, miso_bit}, {PS_STOP, 2'h3});
		pulse(1);
		wait_for(PS_ACTIVE);
		tick(2);
		chk(rx_count[15:0], 16'h0007);
		send(CMD_STOP_TOGGLE_EN, 16'h0000);
		send(CMD_STOP_SOURCE_GPIO, 16'h0001);
		pulse(2);
		tick(8);
		chk(power_state, PS_STOP);
		pulse(2);
		wait_for(PS_ACTIVE);
		tick(2);
		chk(rx_count[15:0], 16'h0009);
		send(CMD_STOP_SOURCE_TMR, 16'h0002);
		pulse(2);
		tick(18);
		chk(power_state, PS_STOP);
		tick(12);
		chk(power_state === PS_STOP, 1'b0);
		wait_for(PS_ACTIVE);
		tick(2);
		chk(rx_count[15:0], 16'h000b);
		send(CMD_STOP_SOURCE_TMR, 16'h0000);
		send(CMD_STOP_SOURCE_GPIO, 16'h0000);
		pulse(0);
		tick(6);
		chk({power_state, reset_busy}, {PS_RESET, 1'b1});
		wait_for(PS_ACTIVE);
		tick(2);
		chk(rx_count[15:0], 16'h000d);
		eth_clk_en = 1'b1;
		tick(30);
		chk(iface_sel, IF_ETH);
		close_out();
	end
endmodule
`default_nettype wire
